// ### verilog/board_power_ctl.v
`timescale 1ns/1ps
`include "power_ctl_defines.vh"

module board_power_ctl #(
	parameter [`HOLD_W-1:0] HOLD_SHORT_CYC = `HOLD_SHORT_CNT,
	parameter [`HOLD_W-1:0] HOLD_LONG_CYC = `HOLD_LONG_CNT,
	parameter [`DEB_W-1:0] DEB_CYC = `DEB_CNT,
	parameter [`WIN_W-1:0] TACH_WIN_CYC = `TACH_WIN_CNT
) (
	input wire clk,
	input wire srst,
	input wire pwr_sw_n,
	input wire rtc_alarm,
	input wire lan_wake,
	input wire usb_activity,
	input wire serial_activity,
	input wire pme_n,
	input wire pcie_wake_n,
	input wire ps2_activity,
	input wire ps2_key_combo,
	input wire ps2_power_key,
	input wire [`FAN_N-1:0] fan_tach,
	input wire pme_wake_en,
	input wire rtc_wake_armed,
	input wire ps2_s5_use_power_key,
	input wire sleep_to_s4,
	input wire restore_last_state,
	input wire prior_state_on,
	input wire led_dual_color,
	input wire os_sleep_req,
	input wire os_off_req,
	input wire [`FAN_N*`PWM_W-1:0] fan_target,
	output reg ps_on,
	output reg [`FAN_N-1:0] fan_pwm,
	output reg led_power,
	output reg led_amber,
	output reg [1:0] sys_state,
	output reg last_on
);

	localparam [1:0] ST_S5 = 2'h0;
	localparam [1:0] ST_S3 = 2'h1;
	localparam [1:0] ST_S4 = 2'h2;
	localparam [1:0] ST_S0 = 2'h3;

	wire [`SYNC_W-1:0] pin_raw;
	reg [`SYNC_W-1:0] sync1_reg;
	reg [`SYNC_W-1:0] sync2_reg;
	reg [`SYNC_W-1:0] sync3_reg;
	reg [`SYNC_W-1:0] pin_reg;
	reg [`SYNC_W-1:0] pin_prev_reg;
	wire [`SYNC_W-1:0] pin_rise;

	// active-low pins are inverted so every bus bit means asserted
	assign pin_raw = {fan_tach, ps2_power_key, ps2_key_combo, ps2_activity,
		~pcie_wake_n, ~pme_n, serial_activity, usb_activity, lan_wake,
		rtc_alarm, ~pwr_sw_n};

	genvar gi;
	generate
		for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (srst) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					sync3_reg[gi] <= 1'b0;
					pin_reg[gi] <= 1'b0;
					pin_prev_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					// a change only counts once two stages agree
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						pin_reg[gi] <= sync3_reg[gi];
					end
					pin_prev_reg[gi] <= pin_reg[gi];
				end
			end
			assign pin_rise[gi] = pin_reg[gi] & ~pin_prev_reg[gi];
		end
	endgenerate

	// power switch debounce and hold timing
	reg [`DEB_W-1:0] deb_cnt_reg;
	reg sw_deb_reg;
	reg sw_deb_prev_reg;
	reg [`HOLD_W-1:0] hold_cnt_reg;
	reg long_done_reg;
	wire sw_release;
	wire short_press;
	wire long_hold;

	always @(posedge clk) begin
		if (srst) begin
			deb_cnt_reg <= {`DEB_W{1'b0}};
			sw_deb_reg <= 1'b0;
		end else if (pin_reg[`IN_SW] == sw_deb_reg) begin
			deb_cnt_reg <= {`DEB_W{1'b0}};
		end else if (deb_cnt_reg >= DEB_CYC - 1'b1) begin
			deb_cnt_reg <= {`DEB_W{1'b0}};
			sw_deb_reg <= pin_reg[`IN_SW];
		end else begin
			deb_cnt_reg <= deb_cnt_reg + 1'b1;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			sw_deb_prev_reg <= 1'b0;
			hold_cnt_reg <= {`HOLD_W{1'b0}};
			long_done_reg <= 1'b0;
		end else begin
			sw_deb_prev_reg <= sw_deb_reg;
			if (!sw_deb_reg) begin
				hold_cnt_reg <= {`HOLD_W{1'b0}};
				long_done_reg <= 1'b0;
			end else if (hold_cnt_reg != HOLD_LONG_CYC) begin
				hold_cnt_reg <= hold_cnt_reg + 1'b1;
			end else begin
				long_done_reg <= 1'b1;
			end
		end
	end

	assign sw_release = sw_deb_prev_reg & ~sw_deb_reg;
	// holds of four to six seconds fall through both tests
	assign short_press = sw_release & (hold_cnt_reg < HOLD_SHORT_CYC);
	assign long_hold = sw_deb_reg & ~long_done_reg &
		(hold_cnt_reg == HOLD_LONG_CYC);

	// wake source gating
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg boot_reg;
	wire in_sleep;
	wire in_s3;
	wire in_s5;
	wire ps2_wake;
	wire wake_req;

	assign in_s3 = (state_reg == ST_S3);
	assign in_s5 = (state_reg == ST_S5);
	assign in_sleep = (state_reg != ST_S0);

	// any key in S3, restricted keys in S4
	// S5 key choice by setting
	// the combination and power key are keystrokes too, so S3 takes them
	assign ps2_wake = in_s3 ? (pin_rise[`IN_PS2] | pin_rise[`IN_COMBO] |
		pin_rise[`IN_PKEY]) :
		in_s5 ? (ps2_s5_use_power_key ? pin_rise[`IN_PKEY] :
		pin_rise[`IN_COMBO]) :
		(pin_rise[`IN_COMBO] | pin_rise[`IN_PKEY]);

	assign wake_req = in_sleep & (
		(rtc_wake_armed & pin_rise[`IN_RTC]) |
		pin_rise[`IN_LAN] |
		(in_s3 & pin_rise[`IN_USB]) |
		(in_s3 & pin_rise[`IN_SER]) |
		(pme_wake_en & pin_rise[`IN_PME]) |
		pin_rise[`IN_PCIE] |
		ps2_wake);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_S5: begin
				if (short_press || wake_req) begin
					state_next = ST_S0;
				end
			end
			ST_S3, ST_S4: begin
				if (long_hold) begin
					state_next = ST_S5;
				end else if (short_press || wake_req) begin
					state_next = ST_S0;
				end
			end
			ST_S0: begin
				if (long_hold || os_off_req) begin
					state_next = ST_S5;
				end else if (short_press || os_sleep_req) begin
					state_next = sleep_to_s4 ? ST_S4 : ST_S3;
				end
			end
			default: begin
				state_next = ST_S5;
			end
		endcase
	end

	// reset stands for AC return; the prior state is sampled just after
	always @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_S5;
			boot_reg <= 1'b1;
		end else if (boot_reg) begin
			boot_reg <= 1'b0;
			if (restore_last_state && prior_state_on) begin
				state_reg <= ST_S0;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs to supply and front panel
	always @(posedge clk) begin
		if (srst) begin
			ps_on <= 1'b0;
			led_power <= 1'b0;
			led_amber <= 1'b0;
			sys_state <= ST_S5;
			last_on <= 1'b0;
		end else begin
			ps_on <= (state_reg == ST_S0);
			led_power <= (state_reg == ST_S0);
			// amber on dual LED, dark on single
			led_amber <= in_s3 & led_dual_color;
			sys_state <= state_reg;
			last_on <= (state_reg == ST_S0);
		end
	end

	// fan control: shared PWM ramp and tach window
	reg [`PWM_W-1:0] pwm_cnt_reg;
	reg [`WIN_W-1:0] win_cnt_reg;
	reg win_end_reg;
	wire fan_en;

	// fans off in any other state
	assign fan_en = (state_reg == ST_S0);

	always @(posedge clk) begin
		if (srst) begin
			pwm_cnt_reg <= {`PWM_W{1'b0}};
			win_cnt_reg <= {`WIN_W{1'b0}};
			win_end_reg <= 1'b0;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
			if (win_cnt_reg >= TACH_WIN_CYC - 1'b1) begin
				win_cnt_reg <= {`WIN_W{1'b0}};
				win_end_reg <= 1'b1;
			end else begin
				win_cnt_reg <= win_cnt_reg + 1'b1;
				win_end_reg <= 1'b0;
			end
		end
	end

	generate
		for (gi = 0; gi < `FAN_N; gi = gi + 1) begin : g_fan
			reg [`PWM_W-1:0] duty_reg;
			reg [`PWM_W-1:0] tach_cnt_reg;
			wire [`PWM_W-1:0] target;
			wire tach_edge;

			assign target = fan_target[gi*`PWM_W +: `PWM_W];
			assign tach_edge = pin_rise[`IN_TACH + gi];

			// tach count steers the duty each window
			always @(posedge clk) begin
				if (srst) begin
					duty_reg <= `DUTY_RST;
					tach_cnt_reg <= `TACH_CNT_RST;
				end else if (win_end_reg) begin
					tach_cnt_reg <= `TACH_CNT_RST;
					if (target == `DUTY_OFF) begin
						duty_reg <= `DUTY_OFF;
					end else if (target == `DUTY_FULL) begin
						duty_reg <= `DUTY_FULL;
					end else if (tach_cnt_reg < target &&
						duty_reg != `DUTY_FULL) begin
						duty_reg <= duty_reg + 1'b1;
					end else if (tach_cnt_reg > target &&
						duty_reg != `DUTY_OFF) begin
						duty_reg <= duty_reg - 1'b1;
					end
				end else if (tach_edge && tach_cnt_reg != `DUTY_FULL) begin
					// saturate so a fast fan never wraps to look slow
					tach_cnt_reg <= tach_cnt_reg + 1'b1;
				end
			end

			// PWM drive; full duty holds the line high
			always @(posedge clk) begin
				if (srst) begin
					fan_pwm[gi] <= 1'b0;
				end else begin
					fan_pwm[gi] <= fan_en & ((duty_reg == `DUTY_FULL) |
						(pwm_cnt_reg < duty_reg));
				end
			end
		end
	endgenerate

endmodule

// ### pkg/power_ctl_defines.vh
`ifndef POWER_CTL_DEFINES_VH
`define POWER_CTL_DEFINES_VH

// clock rate and timing figures
`define CLK_KHZ 20000
`define HOLD_SHORT_MS 4000
`define HOLD_LONG_MS 6000
`define DEBOUNCE_MS 20
`define TACH_WIN_MS 1000

// the same spans in cycles of the 20 MHz clock, sized to their counters
`define HOLD_SHORT_CNT 27'h4C4B400
`define HOLD_LONG_CNT 27'h7270E00
`define DEB_CNT 19'h61A80
`define TACH_WIN_CNT 25'h1312D00

// counter widths and fan count
`define HOLD_W 27
`define DEB_W 19
`define WIN_W 25
`define PWM_W 8
`define FAN_N 3

// reset values and duty limits
`define DUTY_RST 8'h80
`define DUTY_FULL 8'hFF
`define DUTY_OFF 8'h00
`define TACH_CNT_RST 8'h00

// positions in the synchronised pin bus
`define SYNC_W 13
`define IN_SW 0
`define IN_RTC 1
`define IN_LAN 2
`define IN_USB 3
`define IN_SER 4
`define IN_PME 5
`define IN_PCIE 6
`define IN_PS2 7
`define IN_COMBO 8
`define IN_PKEY 9
`define IN_TACH 10

`endif

// ### dv/board_power_ctl_checker.sv
`timescale 1ns/1ps
module board_power_ctl_checker #(
	parameter [26:0] HOLD_SHORT_CYC = 27'hC8,
	parameter [26:0] HOLD_LONG_CYC = 27'h12C
) (
	input wire clk,
	input wire srst,
	input wire pwr_sw_n,
	input wire led_dual_color,
	input wire ps_on,
	input wire led_power,
	input wire led_amber,
	input wire last_on,
	input wire [2:0] fan_pwm,
	input wire [1:0] sys_state
);
	// raw hold length; the design lags it by sync and debounce
	reg [26:0] held;
	always @(posedge clk)
		if (srst || pwr_sw_n)
			held <= 27'h0;
		else if (held != 27'h7FFFFFF)
			held <= held + 27'h1;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	property p_rails;
		ps_on == (sys_state == 2'h3) && last_on == ps_on;
	endproperty
	a_rails: assert property (p_rails)
		else $error("supply enable mismatch");
	property p_fan_off;
		$past(sys_state) != 2'h3 && sys_state != 2'h3 |-> fan_pwm == 3'h0;
	endproperty
	a_fan_off: assert property (p_fan_off)
		else $error("fan driven outside working");
	property p_s3_led;
		sys_state == 2'h1 && $past(sys_state) == 2'h1 && $stable(led_dual_color)
			|-> led_amber == led_dual_color && !led_power;
	endproperty
	a_s3_led: assert property (p_s3_led)
		else $error("sleep indicator wrong");
	property p_short_on;
		$rose(pwr_sw_n) && held inside {[20:HOLD_SHORT_CYC - 20]}
			&& sys_state == 2'h0 |-> ##[1:24] sys_state == 2'h3;
	endproperty
	a_short_on: assert property (p_short_on)
		else $error("short press left soft-off");
	property p_short_sleep;
		$rose(pwr_sw_n) && held inside {[20:HOLD_SHORT_CYC - 20]}
			&& sys_state == 2'h3 |-> ##[1:24] sys_state inside {2'h1, 2'h2};
	endproperty
	a_short_sleep: assert property (p_short_sleep)
		else $error("short press did not sleep");
	property p_short_wake;
		$rose(pwr_sw_n) && held inside {[20:HOLD_SHORT_CYC - 20]}
			&& sys_state inside {2'h1, 2'h2} |-> ##[1:24] sys_state == 2'h3;
	endproperty
	a_short_wake: assert property (p_short_wake)
		else $error("short press did not wake");
	property p_mid;
		$rose(pwr_sw_n) && sys_state == 2'h3 && held inside
			{[HOLD_SHORT_CYC + 20:HOLD_LONG_CYC - 20]}
			|-> ##12 (sys_state == 2'h3) [*8];
	endproperty
	a_mid: assert property (p_mid)
		else $error("mid hold changed state");
	property p_long;
		held == HOLD_LONG_CYC + 27'h14 |-> sys_state == 2'h0 && !ps_on;
	endproperty
	a_long: assert property (p_long)
		else $error("long hold not off");
endmodule
bind board_power_ctl board_power_ctl_checker #(
	.HOLD_SHORT_CYC(HOLD_SHORT_CYC),
	.HOLD_LONG_CYC(HOLD_LONG_CYC)
) chk_u (
	.clk(clk), .srst(srst), .pwr_sw_n(pwr_sw_n),
	.led_dual_color(led_dual_color), .ps_on(ps_on), .led_power(led_power),
	.led_amber(led_amber), .last_on(last_on), .fan_pwm(fan_pwm),
	.sys_state(sys_state)
);

// ### dv/supply_fan_model.sv
`timescale 1ns/1ps
module supply_fan_model (
	input wire clk,
	input wire ps_on,
	input wire [2:0] fan_pwm,
	output reg rail_good = 1'b0,
	output reg [2:0] fan_tach = 3'h0
);
	reg [3:0] ramp = 4'h0;
	always @(posedge clk) begin
		ramp <= ps_on ? {ramp[2:0], 1'b1} : 4'h0;
		rail_good <= ps_on & ramp[3];
		fan_tach <= fan_pwm & {3{rail_good}};
	end
endmodule

// ### dv/test_board_power_ctl.sv
`timescale 1ns/1ps
module test_board_power_ctl;
	reg clk = 1'b0, srst = 1'b1, sw_n = 1'b1, pme_en = 1'b0, armed = 1'b0;
	reg pkey_sel = 1'b0, to_s4 = 1'b0, restore = 1'b0, prior = 1'b0;
	reg dual = 1'b0, sreq = 1'b0, oreq = 1'b0;
	reg [8:0] wk = 9'h0;
	reg [23:0] target = 24'h0;
	reg [2:0] fan_seen = 3'h0;
	reg [2:0] fan_all = 3'h7;
	reg [1:0] st;
	wire ps_on, led_power, led_amber, last_on, rail_good;
	wire [2:0] fan_pwm, fan_tach;
	wire [1:0] sys_state;
	integer errors = 0, compares = 0, i, k;
	board_power_ctl #(.HOLD_SHORT_CYC(27'hC8), .HOLD_LONG_CYC(27'h12C),
		.DEB_CYC(19'h4), .TACH_WIN_CYC(25'h400)) dut_u (
		.clk(clk), .srst(srst), .pwr_sw_n(sw_n), .rtc_alarm(wk[0]),
		.lan_wake(wk[1]), .usb_activity(wk[2]), .serial_activity(wk[3]),
		.pme_n(~wk[4]), .pcie_wake_n(~wk[5]), .ps2_activity(wk[6]),
		.ps2_key_combo(wk[7]), .ps2_power_key(wk[8]), .fan_tach(fan_tach),
		.pme_wake_en(pme_en), .rtc_wake_armed(armed),
		.ps2_s5_use_power_key(pkey_sel), .sleep_to_s4(to_s4),
		.restore_last_state(restore), .prior_state_on(prior),
		.led_dual_color(dual), .os_sleep_req(sreq), .os_off_req(oreq),
		.fan_target(target), .ps_on(ps_on), .fan_pwm(fan_pwm),
		.led_power(led_power), .led_amber(led_amber),
		.sys_state(sys_state), .last_on(last_on));
	supply_fan_model model_u (.clk(clk), .ps_on(ps_on), .fan_pwm(fan_pwm),
		.rail_good(rail_good), .fan_tach(fan_tach));
	initial forever #25 clk = ~clk;
	// which fans were ever driven, and which were driven throughout
	task watch_fans(input integer n);
		begin
			fan_seen = 3'h0;
			fan_all = 3'h7;
			repeat (n) begin
				@(negedge clk);
				fan_seen = fan_seen | fan_pwm;
				fan_all = fan_all & fan_pwm;
			end
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0s exp %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task press(input integer n);
		begin
			sw_n = 1'b0;
			tick(n);
			sw_n = 1'b1;
			tick(30);
		end
	endtask
	task stop_test;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// which sources may wake state t (0 S5, 1 S3, 2 S4)
	function ok(input integer s, input [1:0] t);
		case (s)
			0: ok = armed;
			2, 3, 6: ok = t == 2'h1;
			4: ok = pme_en;
			7: ok = t != 2'h0 || !pkey_sel;
			8: ok = t != 2'h0 || pkey_sel;
			default: ok = 1'b1;
		endcase
	endfunction
	initial begin
		k = $urandom(32'h38604482);
		target = $urandom | 24'h101010;
		tick(16);
		srst = 1'b0;
		tick(2);
		check({sys_state, ps_on, fan_pwm}, 6'h0, "reset");
		press(100);
		check(sys_state, 2'h3, "on");
		watch_fans(300);
		check({rail_good, led_power, last_on, fan_seen}, 6'h3F, "s0 outs");
		// pin one fan fully on and one off; a window end must pass first
		target = {8'hFF, 8'h00, target[7:0]};
		tick(1100);
		watch_fans(300);
		check({fan_all[2], fan_seen[1]}, 2'h2, "fan lim");
		wk = 9'h1FF;
		tick(20);
		wk = 9'h0;
		tick(20);
		check(sys_state, 2'h3, "s0 wake");
		press(250);
		check(sys_state, 2'h3, "mid");
		$display("test switch on done");
		dual = $urandom;
		press(100);
		check({sys_state, ps_on, led_amber, fan_pwm}, {3'h2, dual, 3'h0}, "s3");
		press(100);
		check(sys_state, 2'h3, "s3 wake");
		press(400);
		check({sys_state, rail_good}, 3'h0, "long s0");
		press(100);
		press(100);
		press(400);
		check(sys_state, 2'h0, "long s3");
		$display("test holds done");
		for (i = 0; i < 27; i = i + 1) begin
			{pme_en, armed, pkey_sel} = $urandom;
			st = i % 3;
			if (sys_state !== 2'h3)
				press(100);
			oreq = st == 2'h0;
			sreq = st != 2'h0;
			to_s4 = st[1];
			tick(1);
			{oreq, sreq} = 2'h0;
			tick(10);
			wk[i / 3] = 1'b1;
			tick(20);
			wk = 9'h0;
			tick(20);
			check(sys_state, ok(i / 3, st) ? 2'h3 : st, "wake");
		end
		$display("test wake table done");
		for (i = 0; i < 2; i = i + 1) begin
			srst = 1'b1;
			restore = 1'b1;
			prior = i[0];
			tick(16);
			srst = 1'b0;
			tick(4);
			check(sys_state, i ? 2'h3 : 2'h0, "restore");
		end
		$display("test restore done");
		stop_test;
	end
	initial begin
		#(50 * 40000);
		errors = errors + 1;
		stop_test;
	end
endmodule
